//--- bench/bar3_window_sva.sv
// Checker with assertions and covers on the third window block ports
`timescale 1ns/1ns
module bar3_window_sva (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        warm_rst,
   input wire logic        second_window_is_mem64,
   input wire logic [11:0] reg_addr,
   input wire logic        reg_we,
   input wire logic        reg_re,
   input wire logic [31:0] reg_rdata,
   input wire logic        txn_valid,
   input wire logic [31:0] txn_addr,
   input wire logic        txn_hit,
   input wire logic        txn_out_valid,
   input wire logic [31:0] txn_out_addr,
   input wire logic        window_enabled
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   wire rd_setup = reg_re && reg_addr == bar3_window_pkg::WINDOW_SETUP_OFF;
   wire rd_trans = reg_re && reg_addr == bar3_window_pkg::TRANSLATION_OFF;
   a_rdata_idle_zero: assert property (!reg_re |=> reg_rdata == 32'h00000000)
      else $error("read data not zero when idle");
   a_setup_mem64_zero: assert property (rd_setup && second_window_is_mem64 |=> reg_rdata == 32'h00000000)
      else $error("setup not zero in wide mode");
   a_trans_low_zero: assert property (rd_trans && !second_window_is_mem64 |=> reg_rdata[3:0] == 4'h0)
      else $error("translation low bits not zero");
   a_mem64_no_enable: assert property (second_window_is_mem64 |=> !window_enabled)
      else $error("window enabled in wide mode");
   a_hit_with_valid: assert property (txn_hit |-> txn_out_valid)
      else $error("hit without transaction");
   a_hit_not_mem64: assert property (txn_hit |-> !$past(second_window_is_mem64))
      else $error("hit in wide mode");
   a_low_bits_pass: assert property (txn_valid |=> txn_out_addr[3:0] == $past(txn_addr[3:0]))
      else $error("low address bits changed");
   a_out_valid_follows: assert property (1'b1 |=> txn_out_valid == $past(txn_valid))
      else $error("output valid not delayed copy");
   a_warm_keeps_enable: assert property (window_enabled && warm_rst && !second_window_is_mem64 && !$past(reg_we)
      |=> window_enabled)
      else $error("enable lost on warm reset");
   c_hit: cover property (txn_hit);
   c_warm_enabled: cover property (warm_rst && window_enabled);
   c_setup_mem64: cover property (rd_setup && second_window_is_mem64);
endmodule
bind bar3_window bar3_window_sva chk (.clk(clk), .rst(rst), .warm_rst(warm_rst),
   .second_window_is_mem64(second_window_is_mem64), .reg_addr(reg_addr), .reg_we(reg_we), .reg_re(reg_re),
   .reg_rdata(reg_rdata), .txn_valid(txn_valid), .txn_addr(txn_addr), .txn_hit(txn_hit),
   .txn_out_valid(txn_out_valid), .txn_out_addr(txn_out_addr), .window_enabled(window_enabled));

//--- bench/pcie_requester.sv
// Far side requester that issues transaction addresses
`timescale 1ns/1ns
module pcie_requester (
   input  wire logic        clk,
   output logic             txn_valid,
   output logic      [31:0] txn_addr
);
   initial begin
      txn_valid = 1'b0;
      txn_addr  = 32'h00000000;
   end
   // One address per request, then the inverse so nothing stale lingers
   task automatic send(input logic [31:0] a);
      @(posedge clk);
      txn_valid <= 1'b1;
      txn_addr  <= a;
      @(posedge clk);
      txn_valid <= 1'b0;
      txn_addr  <= ~a;
   endtask
endmodule

//--- bench/tb.sv
// Self-checking bench for the third window block
`timescale 1ns/1ns
module tb;
   localparam logic [11:0] SU = bar3_window_pkg::WINDOW_SETUP_OFF;
   localparam logic [11:0] TR = bar3_window_pkg::TRANSLATION_OFF;
   localparam logic [11:0] BA = bar3_window_pkg::WINDOW_BASE_OFF;
   logic        clk, rst, warm_rst, second_window_is_mem64, reg_we, reg_re;
   logic        txn_valid, txn_hit, txn_out_valid, window_enabled;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, txn_addr, txn_out_addr;
   logic [27:0] m;
   int          err_count = 0;
   int          checked = 0;
   int          sz[5] = '{0, 3, 4, 12, 31};
   logic [31:0] ad[2] = '{32'hfffff00f, 32'hfffffff3};
   bar3_window dut (.clk(clk), .rst(rst), .warm_rst(warm_rst), .second_window_is_mem64(second_window_is_mem64),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
      .txn_valid(txn_valid), .txn_addr(txn_addr), .txn_hit(txn_hit), .txn_out_valid(txn_out_valid),
      .txn_out_addr(txn_out_addr), .window_enabled(window_enabled));
   pcie_requester host (.clk(clk), .txn_valid(txn_valid), .txn_addr(txn_addr));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      tally_and_finish();
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_we    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_we    <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_re   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_re   <= 1'b0;
      #1 chk("read data", e, reg_rdata);
   endtask
   task automatic xa(input logic [31:0] a, input logic h, input logic [31:0] o);
      host.send(a);
      #1 chk("hit", {31'h0, h}, {31'h0, txn_hit});
      chk("out valid", 32'h1, {31'h0, txn_out_valid});
      if (h) chk("out addr", o, txn_out_addr);
   endtask
   function automatic logic [27:0] mk(input int s);
      for (int i = 0; i < 28; i++) mk[i] = s == 0 || (s >= 4 && i + 4 >= s);
   endfunction
   initial begin
      {rst, warm_rst, second_window_is_mem64, reg_we, reg_re} = 5'h10;
      reg_addr  = 12'h000;
      reg_wdata = 32'h00000000;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(SU, 32'h00000010);
      rd(TR, 32'h00000000);
      rd(BA, 32'h00000000);
      rd(12'h0a0, 32'h00000000);
      $display("test reset values done");
      foreach (sz[k]) begin
         m = mk(sz[k]);
         wr(SU, 32'h80000000 | (32'(sz[k]) << 4));
         wr(BA, 32'hffffffff);
         rd(BA, {m, 4'h0});
         wr(TR, 32'h5a5a5a5f);
         rd(TR, 32'h5a5a5a50);
         foreach (ad[j]) xa(ad[j], (sz[k] == 0 || sz[k] >= 4) && ((~ad[j][31:4] & m) == 28'h0),
            {(28'h5a5a5a5 & m) | (ad[j][31:4] & ~m), ad[j][3:0]});
      end
      $display("test size sweep done");
      wr(SU, 32'h80000041);
      wr(BA, 32'habcdef57);
      rd(BA, 32'habcdef51);
      xa(32'habcdef5a, 1'b1, 32'h5a5a5a5a);
      chk("enabled", 32'h1, {31'h0, window_enabled});
      wr(SU, 32'h00000041);
      rd(BA, 32'h00000000);
      xa(32'habcdef5a, 1'b0, 32'h00000000);
      chk("enabled", 32'h0, {31'h0, window_enabled});
      $display("test io window done");
      wr(SU, 32'h80000041);
      @(posedge clk);
      warm_rst <= 1'b1;
      @(posedge clk);
      warm_rst <= 1'b0;
      rd(SU, 32'h80000010);
      rd(TR, 32'h5a5a5a50);
      $display("test warm reset done");
      @(posedge clk);
      second_window_is_mem64 <= 1'b1;
      rd(SU, 32'h00000000);
      wr(SU, 32'h800000c0);
      wr(TR, 32'hdeadbeef);
      rd(TR, 32'hdeadbeef);
      xa(32'hfffffff3, 1'b0, 32'h00000000);
      chk("enabled", 32'h0, {31'h0, window_enabled});
      @(posedge clk);
      second_window_is_mem64 <= 1'b0;
      rd(SU, 32'h80000010);
      $display("test wide mode done");
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      rd(TR, 32'h00000000);
      rd(SU, 32'h00000010);
      $display("test power reset done");
      tally_and_finish();
   end
endmodule

//--- common/bar3_window_pkg.sv
// Register map, field layout and reset values of the third window block
package bar3_window_pkg;
   localparam int unsigned ADDR_W         = 12;
   localparam int unsigned DATA_W         = 32;
   localparam int unsigned SIZE_W         = 6;
   localparam int unsigned BASE_LSB       = 4;
   localparam int unsigned BASE_W         = 28;
   // Register offsets
   localparam logic [11:0] WINDOW_BASE_OFF   = 12'h01c;
   localparam logic [11:0] WINDOW_SETUP_OFF  = 12'h094;
   localparam logic [11:0] TRANSLATION_OFF   = 12'h098;
   // Setup register field positions
   localparam int unsigned SPACE_KIND_BIT = 0;
   localparam int unsigned TYPE_LSB       = 1;
   localparam int unsigned TYPE_MSB       = 2;
   localparam int unsigned PREF_BIT       = 3;
   localparam int unsigned SIZE_LSB       = 4;
   localparam int unsigned SIZE_MSB       = 9;
   localparam int unsigned ENABLE_BIT     = 31;
   // Reset values and limits
   localparam logic [5:0]  SIZE_RESET     = 6'h01;
   localparam logic [5:0]  SIZE_MIN_OK    = 6'h04;
   localparam logic [1:0]  TYPE_RESET     = 2'h0;
   localparam logic [27:0] BASE_RESET     = 28'h0000000;
   localparam logic [31:0] TRANS_RESET    = 32'h00000000;
   localparam logic        SPACE_MEMORY   = 1'b0;
   localparam logic        SPACE_IO       = 1'b1;
endpackage

//--- rtl/bar3_window.sv
// Third window sizing, enable, decode and address translation
`timescale 1ns/1ns
// Overview of operation
// - Six-bit size field gives window size as power of two; zero compares every base bit, like size four.
// - Lowest base field bit maps to address bit 4, upward in order.
// - Size zero makes every base field bit writable.
// - Size four or more: base bits at or above size writable, others read zero.
// - Size one to three forces all base bits to read-only zero.
// - Size four is accepted as the smallest 16-byte I/O window.
// - Size field is read-write and resets to 0x01.
// - Enable bit 31; cleared means no decode and base register reads zero.
// - Enable and translated base survive warm reset; power-on reset clears them.
// - Second window 64-bit memory: translation register fully read-write upper half.
// - Otherwise translation bits 3:0 read zero, bits 31:4 read-write, reset zero.
// - Translation replaces address bits 31 down to size with translated base.
// - Second window 64-bit memory: setup register reads constant zero.
// - Space-kind select: 0 memory, 1 I/O, reported in base register.
module bar3_window (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        warm_rst,
   input  wire logic        second_window_is_mem64,
   input  wire logic [11:0] reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_we,
   input  wire logic        reg_re,
   output logic      [31:0] reg_rdata,
   input  wire logic        txn_valid,
   input  wire logic [31:0] txn_addr,
   output logic             txn_hit,
   output logic             txn_out_valid,
   output logic      [31:0] txn_out_addr,
   output logic             window_enabled
);

   // Setup register state
   logic                                      space_kind_select_q;
   logic                                      space_kind_select_d;
   logic [1:0]                                type_q;
   logic [1:0]                                type_d;
   logic                                      pref_q;
   logic                                      pref_d;
   logic [bar3_window_pkg::SIZE_W-1:0]        size_q;
   logic [bar3_window_pkg::SIZE_W-1:0]        size_d;
   logic                                      enable_q;
   logic                                      enable_d;

   // Window base and translation state
   logic [bar3_window_pkg::BASE_W-1:0]        window_base_bits_q;
   logic [bar3_window_pkg::BASE_W-1:0]        window_base_bits_d;
   logic [31:0]                               translation_q;
   logic [31:0]                               translation_d;

   // Outputs
   logic [31:0]                               rdata_q;
   logic [31:0]                               rdata_d;
   logic                                      hit_q;
   logic                                      hit_d;
   logic                                      out_valid_q;
   logic [31:0]                               out_addr_q;
   logic [31:0]                               out_addr_d;
   logic                                      enabled_q;

   // Decode
   wire logic sel_setup = reg_addr == bar3_window_pkg::WINDOW_SETUP_OFF;
   wire logic sel_trans = reg_addr == bar3_window_pkg::TRANSLATION_OFF;
   wire logic sel_base  = reg_addr == bar3_window_pkg::WINDOW_BASE_OFF;
   wire logic wr_setup  = reg_we && sel_setup && !second_window_is_mem64;
   wire logic wr_trans  = reg_we && sel_trans;
   wire logic wr_base   = reg_we && sel_base;

   // Size interpretation
   wire logic size_zero   = size_q == '0;
   wire logic size_usable = size_zero || (size_q >= bar3_window_pkg::SIZE_MIN_OK);
   wire logic enable_eff  = enable_q && !second_window_is_mem64;
   wire logic is_io       = space_kind_select_q == bar3_window_pkg::SPACE_IO;

   // Per-bit mask of base bits that are writable and compared
   logic [bar3_window_pkg::BASE_W-1:0] base_mask;

   genvar gi;
   generate
      for (gi = 0; gi < bar3_window_pkg::BASE_W; gi = gi + 1) begin : g_mask
         // Field bit gi stands for address bit gi+4
         localparam logic [6:0] ADDR_POS = 7'(gi + bar3_window_pkg::BASE_LSB);
         assign base_mask[gi] = size_zero ||
                                (size_usable && (ADDR_POS >= {1'b0, size_q}));
      end
   endgenerate

   // Base register write: non-writable bits stay zero
   wire logic [bar3_window_pkg::BASE_W-1:0] base_wr_val =
      reg_wdata[31:bar3_window_pkg::BASE_LSB] & base_mask;
   wire logic [bar3_window_pkg::BASE_W-1:0] base_visible =
      window_base_bits_q & base_mask;

   // Low translation bits writable only in 64-bit upper-half mode
   wire logic [3:0] trans_low_wr =
      second_window_is_mem64 ? reg_wdata[3:0] : 4'h0;
   wire logic [3:0] trans_low_rd =
      second_window_is_mem64 ? translation_q[3:0] : 4'h0;

   // Register read views
   wire logic [1:0] type_rd = is_io ? 2'h0 : type_q;
   wire logic       pref_rd = is_io ? 1'b0 : pref_q;

   wire logic [31:0] setup_rd = second_window_is_mem64 ? 32'h00000000 :
      {enable_q, 21'h000000, size_q, pref_q, type_rd, space_kind_select_q};

   wire logic [31:0] base_rd = !enable_eff ? 32'h00000000 :
      {base_visible, pref_rd, type_rd, space_kind_select_q};

   wire logic [31:0] trans_rd = {translation_q[31:4], trans_low_rd};

   always_comb begin
      rdata_d = 32'h00000000;
      if (reg_re) begin
         if (sel_setup) begin
            rdata_d = setup_rd;
         end else if (sel_trans) begin
            rdata_d = trans_rd;
         end else if (sel_base) begin
            rdata_d = base_rd;
         end
      end
   end

   // Setup field values carried by a setup write
   wire logic                               wr_space_kind = reg_wdata[bar3_window_pkg::SPACE_KIND_BIT];
   wire logic [1:0]                         wr_type       =
      reg_wdata[bar3_window_pkg::TYPE_MSB:bar3_window_pkg::TYPE_LSB];
   wire logic                               wr_pref       = reg_wdata[bar3_window_pkg::PREF_BIT];
   wire logic [bar3_window_pkg::SIZE_W-1:0] wr_size       =
      reg_wdata[bar3_window_pkg::SIZE_MSB:bar3_window_pkg::SIZE_LSB];
   wire logic                               wr_enable     = reg_wdata[bar3_window_pkg::ENABLE_BIT];

   // Next space kind
   always_comb begin
      space_kind_select_d = space_kind_select_q;
      if (wr_setup) begin
         space_kind_select_d = wr_space_kind;
      end
   end

   // Next address type
   always_comb begin
      type_d = type_q;
      if (wr_setup) begin
         type_d = wr_type;
      end
   end

   // Next prefetch flag
   always_comb begin
      pref_d = pref_q;
      if (wr_setup) begin
         pref_d = wr_pref;
      end
   end

   // Next size field
   always_comb begin
      size_d = size_q;
      if (wr_setup) begin
         size_d = wr_size;
      end
   end

   // Next enable bit
   always_comb begin
      enable_d = enable_q;
      if (wr_setup) begin
         enable_d = wr_enable;
      end
   end

   // Next value of base and translation
   always_comb begin
      window_base_bits_d = window_base_bits_q;
      if (wr_base) begin
         window_base_bits_d = base_wr_val;
      end
   end

   always_comb begin
      translation_d = translation_q;
      if (wr_trans) begin
         translation_d = {reg_wdata[31:4], trans_low_wr};
      end
   end

   // Decode and translate, one slice per base field bit
   wire logic [bar3_window_pkg::BASE_W-1:0] addr_hi = txn_addr[31:bar3_window_pkg::BASE_LSB];
   logic      [bar3_window_pkg::BASE_W-1:0] bit_miss;
   logic      [bar3_window_pkg::BASE_W-1:0] xlat_hi;

   generate
      for (gi = 0; gi < bar3_window_pkg::BASE_W; gi = gi + 1) begin : g_xlat
         // Compared and replaced bits are exactly the writable ones
         assign bit_miss[gi] = (addr_hi[gi] ^ window_base_bits_q[gi]) & base_mask[gi];
         assign xlat_hi[gi]  = base_mask[gi] ? translation_q[gi + bar3_window_pkg::BASE_LSB] : addr_hi[gi];
      end
   endgenerate

   wire logic addr_match  = bit_miss == '0;
   wire logic out_valid_d = txn_valid;
   wire logic enabled_d   = enable_eff;

   always_comb begin
      hit_d      = txn_valid && enable_eff && size_usable && addr_match;
      out_addr_d = {xlat_hi, txn_addr[3:0]};
   end

   // Space kind, cleared by power-on and warm resets
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         space_kind_select_q <= bar3_window_pkg::SPACE_MEMORY;
      end else if (warm_rst) begin
         space_kind_select_q <= bar3_window_pkg::SPACE_MEMORY;
      end else begin
         space_kind_select_q <= space_kind_select_d;
      end
   end

   // Address type, cleared by both resets
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         type_q <= bar3_window_pkg::TYPE_RESET;
      end else if (warm_rst) begin
         type_q <= bar3_window_pkg::TYPE_RESET;
      end else begin
         type_q <= type_d;
      end
   end

   // Prefetch flag, cleared by both resets
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pref_q <= 1'b0;
      end else if (warm_rst) begin
         pref_q <= 1'b0;
      end else begin
         pref_q <= pref_d;
      end
   end

   // Size field, back to its reset value on both resets
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         size_q <= bar3_window_pkg::SIZE_RESET;
      end else if (warm_rst) begin
         size_q <= bar3_window_pkg::SIZE_RESET;
      end else begin
         size_q <= size_d;
      end
   end

   // Window base bits, cleared by both resets
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         window_base_bits_q <= bar3_window_pkg::BASE_RESET;
      end else if (warm_rst) begin
         window_base_bits_q <= bar3_window_pkg::BASE_RESET;
      end else begin
         window_base_bits_q <= window_base_bits_d;
      end
   end

   // Enable bit, kept across warm reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enable_q <= 1'b0;
      end else begin
         enable_q <= enable_d;
      end
   end

   // Translation register, kept across warm reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         translation_q <= bar3_window_pkg::TRANS_RESET;
      end else begin
         translation_q <= translation_d;
      end
   end

   // Read data, one cycle after the read strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 32'h00000000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Hit flag
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hit_q <= 1'b0;
      end else begin
         hit_q <= hit_d;
      end
   end

   // Delayed transaction valid
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_valid_q <= 1'b0;
      end else begin
         out_valid_q <= out_valid_d;
      end
   end

   // Translated address
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_addr_q <= 32'h00000000;
      end else begin
         out_addr_q <= out_addr_d;
      end
   end

   // Effective enable
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enabled_q <= 1'b0;
      end else begin
         enabled_q <= enabled_d;
      end
   end

   assign reg_rdata      = rdata_q;
   assign txn_hit        = hit_q;
   assign txn_out_valid  = out_valid_q;
   assign txn_out_addr   = out_addr_q;
   assign window_enabled = enabled_q;

endmodule
